//--- rtl/cbe_pkg.sv
package cbe_pkg;
   // Opcode encodings of the relative branch family
   localparam logic [7:0] OP_BRANCH_ALWAYS = 8'h20;
   localparam logic [7:0] OP_BRANCH_NEVER = 8'h21;
   localparam logic [7:0] OP_BRANCH_HIGHER_UNSIGNED = 8'h22;
   localparam logic [7:0] OP_BRANCH_LOWER_SAME_UNSIGNED = 8'h23;
   localparam logic [7:0] OP_BRANCH_HIGHER_SAME_CARRY_CLEAR = 8'h24;
   localparam logic [7:0] OP_BRANCH_LOWER_CARRY_SET = 8'h25;
   localparam logic [7:0] OP_BRANCH_IF_NOT_EQUAL = 8'h26;
   localparam logic [7:0] OP_BRANCH_IF_EQUAL = 8'h27;
   localparam logic [7:0] OP_BRANCH_OVERFLOW_CLEAR = 8'h28;
   localparam logic [7:0] OP_BRANCH_OVERFLOW_SET = 8'h29;
   localparam logic [7:0] OP_BRANCH_IF_PLUS = 8'h2a;
   localparam logic [7:0] OP_BRANCH_IF_MINUS = 8'h2b;
   localparam logic [7:0] OP_BRANCH_GREATER_EQUAL_SIGNED = 8'h2c;
   localparam logic [7:0] OP_BRANCH_LESS_SIGNED = 8'h2d;
   localparam logic [7:0] OP_BRANCH_GREATER_SIGNED = 8'h2e;
   localparam logic [7:0] OP_BRANCH_LESS_EQUAL_SIGNED = 8'h2f;
   // Upper nibble shared by the whole family
   localparam logic [3:0] OP_FAMILY_NIBBLE = 4'h2;
   // Fixed bus figures
   localparam logic [15:0] DUMMY_ADDR = 16'hffff;
   localparam logic [15:0] BRANCH_LEN = 16'h0002;
   localparam int BRANCH_CYCLES = 3;
   // Reset values
   localparam logic [15:0] PC_RESET = 16'h0000;

   // Condition code flags examined by branches
   typedef struct packed {
      logic negative_flag;
      logic zero_flag;
      logic overflow_flag;
      logic carry_flag;
   } cbe_ccr_t;

   // Bus cycle phase of a branch
   typedef enum logic [1:0] {
      CBE_IDLE = 2'b00,
      CBE_FETCH_OP = 2'b01,
      CBE_FETCH_OFS = 2'b10,
      CBE_DUMMY = 2'b11
   } cbe_phase_t;

   // Read request toward program memory
   typedef struct packed {
      logic rd;
      logic [15:0] addr;
   } cbe_bus_t;
endpackage : cbe_pkg

//--- rtl/cbe_cond_test.sv
`timescale 1ns/1ps
`default_nettype none
// Pure test of the condition codes for one opcode
module cbe_cond_test
   import cbe_pkg::*;
(
   // Decoded operands
   input wire logic [7:0] i_opcode,
   input wire cbe_pkg::cbe_ccr_t i_ccr,
   // Result
   output logic o_taken,
   output logic o_is_branch
);
   import cbe_pkg::*;

   // Shorthand for the flags
   logic n, z, v, c;
   assign n = i_ccr.negative_flag;
   assign z = i_ccr.zero_flag;
   assign v = i_ccr.overflow_flag;
   assign c = i_ccr.carry_flag;

   // Family membership by upper nibble
   assign o_is_branch = (i_opcode[7:4] == OP_FAMILY_NIBBLE);

   // Condition table
   always_comb begin
      case (i_opcode)
         OP_BRANCH_ALWAYS: o_taken = 1'b1;
         OP_BRANCH_NEVER: o_taken = 1'b0;
         OP_BRANCH_HIGHER_UNSIGNED: o_taken = ~(c | z);
         OP_BRANCH_LOWER_SAME_UNSIGNED: o_taken = c | z;
         OP_BRANCH_HIGHER_SAME_CARRY_CLEAR: o_taken = ~c;
         OP_BRANCH_LOWER_CARRY_SET: o_taken = c;
         OP_BRANCH_IF_NOT_EQUAL: o_taken = ~z;
         OP_BRANCH_IF_EQUAL: o_taken = z;
         OP_BRANCH_OVERFLOW_CLEAR: o_taken = ~v;
         OP_BRANCH_OVERFLOW_SET: o_taken = v;
         OP_BRANCH_IF_PLUS: o_taken = ~n;
         OP_BRANCH_IF_MINUS: o_taken = n;
         OP_BRANCH_GREATER_EQUAL_SIGNED: o_taken = ~(n ^ v);
         OP_BRANCH_LESS_SIGNED: o_taken = n ^ v;
         OP_BRANCH_GREATER_SIGNED: o_taken = ~(z | (n ^ v));
         OP_BRANCH_LESS_EQUAL_SIGNED: o_taken = z | (n ^ v);
         // Not a branch
         default: o_taken = 1'b0;
      endcase
   end
endmodule : cbe_cond_test
`default_nettype wire

//--- rtl/cbe_branch_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Minus opcode branches when negative flag set
// - Not-equal opcode branches when zero flag clear
// - Plus opcode branches when negative flag clear
// - Taken target is opcode address+2+offset
// - Three reads: opcode, offset, dummy FFFF
// - Condition code flags never modified
// - Signed tests from zero, negative, overflow
// - Unsigned tests from carry and zero
// - Equal, overflow, always, never tests
// - Offset byte is sign extended
module cbe_branch_unit
   import cbe_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // Start of a branch at the given address
   input wire logic i_start,
   input wire logic [15:0] i_op_addr,
   // Condition codes from the core
   input wire cbe_pkg::cbe_ccr_t i_ccr,
   // Read data from program memory
   input wire logic [7:0] i_rd_data,
   // Program memory read request
   output cbe_pkg::cbe_bus_t o_bus,
   // Completion and results
   output logic o_busy,
   output logic o_done,
   output logic o_taken,
   output logic o_illegal,
   output logic [15:0] o_pc,
   output cbe_pkg::cbe_ccr_t o_ccr
);
   import cbe_pkg::*;

   // Reset synchroniser; first stage only feeds the second
   logic rst_meta_n, rst_n;
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // All state of the unit except the reset synchroniser
   typedef struct packed {
      cbe_phase_t phase;
      logic [15:0] op_addr;
      logic [7:0] opcode;
      cbe_ccr_t condition_code_register;
      cbe_bus_t bus;
      logic done;
      logic taken;
      logic illegal;
      logic [15:0] pc;
   } cbe_state_t;

   cbe_state_t st, next_st;

   // Condition evaluation on the latched opcode and flags
   logic cond_taken, cond_is_branch;
   cbe_cond_test u_test (
      .i_opcode(st.opcode),
      .i_ccr(st.condition_code_register),
      .o_taken(cond_taken),
      .o_is_branch(cond_is_branch)
   );

   // Next-state logic
   always_comb begin
      logic [15:0] seq_pc;
      logic [15:0] ofs;
      seq_pc = 16'h0000;
      ofs = 16'h0000;
      next_st = st;
      next_st.done = 1'b0;
      // Following instruction address, used by both outcomes
      seq_pc = st.op_addr + BRANCH_LEN;
      ofs = {{8{i_rd_data[7]}}, i_rd_data};
      case (st.phase)
         CBE_IDLE: begin
            next_st.bus.rd = 1'b0;
            // Flags sampled at start; held untouched afterwards
            if (i_start) begin
               next_st.phase = CBE_FETCH_OP;
               next_st.op_addr = i_op_addr;
               next_st.condition_code_register = i_ccr;
               next_st.bus.rd = 1'b1;
               next_st.bus.addr = i_op_addr;
            end
         end
         CBE_FETCH_OP: begin
            // Opcode returns during cycle 1
            next_st.opcode = i_rd_data;
            next_st.phase = CBE_FETCH_OFS;
            next_st.bus.addr = st.op_addr + 16'h0001;
         end
         CBE_FETCH_OFS: begin
            next_st.phase = CBE_DUMMY;
            next_st.bus.addr = DUMMY_ADDR;
            next_st.illegal = ~cond_is_branch;
            if (cond_is_branch && cond_taken) begin
               next_st.pc = seq_pc + ofs;
               next_st.taken = 1'b1;
            end else begin
               next_st.pc = seq_pc;
               next_st.taken = 1'b0;
            end
         end
         CBE_DUMMY: begin
            // Done pulses as the dummy cycle ends; pc, taken and illegal were set as the offset cycle ended
            next_st.phase = CBE_IDLE;
            next_st.bus.rd = 1'b0;
            next_st.done = 1'b1;
         end
         default: begin
            next_st.phase = CBE_IDLE;
            next_st.bus.rd = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{phase: CBE_IDLE, op_addr: PC_RESET, opcode: 8'h00, condition_code_register: '0,
                 bus: '0, done: 1'b0, taken: 1'b0, illegal: 1'b0, pc: PC_RESET};
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state flops
   assign o_bus = st.bus;
   assign o_busy = st.bus.rd;
   assign o_done = st.done;
   assign o_taken = st.taken;
   assign o_illegal = st.illegal;
   assign o_pc = st.pc;
   assign o_ccr = st.condition_code_register;

   // Checks
   // dummy address
   chk_dummy_addr: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.phase == CBE_DUMMY |-> st.bus.rd && st.bus.addr == DUMMY_ADDR)
      else $error("third cycle not at dummy address");
   chk_three_reads: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      $rose(st.bus.rd) |-> st.bus.rd [*3] ##1 !st.bus.rd ##0 st.done)
      else $error("branch did not take three reads");
   chk_offset_addr: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      $rose(st.bus.rd) |=> st.bus.addr == $past(st.bus.addr) + 16'h0001)
      else $error("offset read at wrong address");
   chk_done_pulse: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.done |=> !st.done)
      else $error("done held longer than one cycle");
   chk_ccr_hold: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.phase != CBE_IDLE |=> $stable(o_ccr))
      else $error("flags changed during branch");
   chk_taken_pc: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.phase == CBE_FETCH_OFS && cond_taken && cond_is_branch |=>
      st.pc == st.op_addr + BRANCH_LEN + {{8{$past(i_rd_data[7])}}, $past(i_rd_data)})
      else $error("taken target wrong");
   chk_fall_pc: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.done && !st.taken |-> st.pc == st.op_addr + BRANCH_LEN)
      else $error("untaken branch did not fall through");
   chk_minus_test: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.opcode == OP_BRANCH_IF_MINUS && st.phase == CBE_DUMMY |->
      st.taken == st.condition_code_register.negative_flag)
      else $error("minus test wrong");
   chk_not_equal: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.opcode == OP_BRANCH_IF_NOT_EQUAL && st.phase == CBE_DUMMY |->
      st.taken == !st.condition_code_register.zero_flag)
      else $error("not equal test wrong");
   chk_plus_test: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.opcode == OP_BRANCH_IF_PLUS && st.phase == CBE_DUMMY |->
      st.taken == !st.condition_code_register.negative_flag)
      else $error("plus test wrong");
   chk_signed_gt: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.opcode == OP_BRANCH_GREATER_SIGNED && st.phase == CBE_DUMMY |->
      st.taken == !(st.condition_code_register.zero_flag | (st.condition_code_register.negative_flag ^ st.condition_code_register.overflow_flag)))
      else $error("signed greater test wrong");
   chk_signed_ge: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.opcode == OP_BRANCH_GREATER_EQUAL_SIGNED && st.phase == CBE_DUMMY |->
      st.taken == !(st.condition_code_register.negative_flag ^ st.condition_code_register.overflow_flag))
      else $error("signed greater or equal test wrong");
   chk_unsigned_hi: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.opcode == OP_BRANCH_HIGHER_UNSIGNED && st.phase == CBE_DUMMY |->
      st.taken == !(st.condition_code_register.carry_flag | st.condition_code_register.zero_flag))
      else $error("unsigned higher test wrong");
   chk_lower_same: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.opcode == OP_BRANCH_LOWER_SAME_UNSIGNED && st.phase == CBE_DUMMY |->
      st.taken == (st.condition_code_register.carry_flag | st.condition_code_register.zero_flag))
      else $error("unsigned lower or same test wrong");
   chk_equal_test: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.opcode == OP_BRANCH_IF_EQUAL && st.phase == CBE_DUMMY |->
      st.taken == st.condition_code_register.zero_flag)
      else $error("equal test wrong");
   chk_never_test: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.opcode == OP_BRANCH_NEVER && st.phase == CBE_DUMMY |-> !st.taken)
      else $error("never branch was taken");
   chk_sign_ext: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.phase == CBE_FETCH_OFS && i_rd_data[7] && cond_taken && cond_is_branch |=>
      (st.pc < st.op_addr + BRANCH_LEN) || (st.op_addr + BRANCH_LEN < 16'h0080))
      else $error("negative offset moved forward");

   cov_taken: cover property (@(posedge i_ref_clk) disable iff (!rst_n) st.done && st.taken);
   cov_untaken: cover property (@(posedge i_ref_clk) disable iff (!rst_n) st.done && !st.taken);
   cov_back: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
      st.phase == CBE_FETCH_OFS && i_rd_data[7] && cond_taken);
   cov_illegal: cover property (@(posedge i_ref_clk) disable iff (!rst_n) st.done && st.illegal);
endmodule : cbe_branch_unit
`default_nettype wire

//--- tb/cbe_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Program memory answering the branch unit in the same cycle
module cbe_mem_model
   import cbe_pkg::*;
(
   // Clock and request
   input wire logic i_ref_clk,
   input wire cbe_pkg::cbe_bus_t i_bus,
   // Instruction placed at i_base
   input wire logic [15:0] i_base,
   input wire logic [7:0] i_opcode,
   input wire logic [7:0] i_offset,
   // Answer
   output logic [7:0] o_rd_data
);
   logic [7:0] junk = 8'h5a; // Filler for unused cycles
   // Filler changes every cycle so a stale byte never looks valid
   always @(posedge i_ref_clk) begin
      junk <= {junk[6:0], junk[7] ^ junk[5]};
   end
   always_comb begin
      if (i_bus.rd && i_bus.addr == i_base) begin
         o_rd_data = i_opcode;
      end else if (i_bus.rd && i_bus.addr == i_base + 16'h0001) begin
         o_rd_data = i_offset;
      end else begin
         o_rd_data = junk; // Dummy read carries nothing
      end
   end
endmodule : cbe_mem_model
`default_nettype wire

//--- tb/conditional_branch_evaluator_tb.sv
`timescale 1ns/1ps
`default_nettype none
module conditional_branch_evaluator_tb;
   import cbe_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_start = 1'b0;
   logic [15:0] i_op_addr = 16'h0000;
   cbe_ccr_t i_ccr = '0;
   logic [7:0] i_rd_data;
   cbe_bus_t o_bus;
   logic o_busy;
   logic o_done;
   logic o_taken;
   logic o_illegal;
   logic [15:0] o_pc;
   cbe_ccr_t o_ccr;
   logic [15:0] cur_addr = 16'h0000; // Where the memory holds the branch
   logic [7:0] cur_op = 8'h00;
   logic [7:0] cur_ofs = 8'h00;
   int num_errors = 0;
   int checks = 0;
   logic [31:0] seed = 32'h0000b8c5;
   // Free running clock
   always #5 i_ref_clk = ~i_ref_clk;
   cbe_branch_unit dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_start(i_start),
      .i_op_addr(i_op_addr), .i_ccr(i_ccr), .i_rd_data(i_rd_data), .o_bus(o_bus),
      .o_busy(o_busy), .o_done(o_done), .o_taken(o_taken), .o_illegal(o_illegal),
      .o_pc(o_pc), .o_ccr(o_ccr));
   cbe_mem_model mem (.i_ref_clk(i_ref_clk), .i_bus(o_bus), .i_base(cur_addr),
      .i_opcode(cur_op), .i_offset(cur_ofs), .o_rd_data(i_rd_data));
   // Repeatable random source
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xorshift
   // Expected branch decision per opcode
   function automatic logic exp_taken(logic [7:0] op, cbe_ccr_t f);
      case (op)
         OP_BRANCH_ALWAYS: return 1'b1;
         OP_BRANCH_NEVER: return 1'b0;
         OP_BRANCH_HIGHER_UNSIGNED: return !(f.carry_flag | f.zero_flag);
         OP_BRANCH_LOWER_SAME_UNSIGNED: return f.carry_flag | f.zero_flag;
         OP_BRANCH_HIGHER_SAME_CARRY_CLEAR: return !f.carry_flag;
         OP_BRANCH_LOWER_CARRY_SET: return f.carry_flag;
         OP_BRANCH_IF_NOT_EQUAL: return !f.zero_flag;
         OP_BRANCH_IF_EQUAL: return f.zero_flag;
         OP_BRANCH_OVERFLOW_CLEAR: return !f.overflow_flag;
         OP_BRANCH_OVERFLOW_SET: return f.overflow_flag;
         OP_BRANCH_IF_PLUS: return !f.negative_flag;
         OP_BRANCH_IF_MINUS: return f.negative_flag;
         OP_BRANCH_GREATER_EQUAL_SIGNED: return !(f.negative_flag ^ f.overflow_flag);
         OP_BRANCH_LESS_SIGNED: return f.negative_flag ^ f.overflow_flag;
         OP_BRANCH_GREATER_SIGNED:
            return !(f.zero_flag | (f.negative_flag ^ f.overflow_flag));
         OP_BRANCH_LESS_EQUAL_SIGNED:
            return f.zero_flag | (f.negative_flag ^ f.overflow_flag);
         default: return 1'b0; // Not a branch
      endcase
   endfunction : exp_taken
   // Compare and count
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   // Verdict and end of run
   task automatic test_done();
      if (num_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   // One branch; hold keeps a refused start up while busy
   task automatic run(input logic [7:0] op, input logic [7:0] ofs, input logic [15:0] a,
         input cbe_ccr_t f, input logic hold);
      logic tk;
      logic ill;
      logic [15:0] pc_exp;
      ill = op[7:4] != OP_FAMILY_NIBBLE;
      tk = exp_taken(op, f) && !ill;
      pc_exp = a + BRANCH_LEN + (tk ? {{8{ofs[7]}}, ofs} : 16'h0000);
      cur_addr = a;
      cur_op = op;
      cur_ofs = ofs;
      i_start = 1'b1;
      i_op_addr = a;
      i_ccr = f;
      @(negedge i_ref_clk);
      // Start is ignored while busy; flags must be taken at start only
      i_start = hold;
      i_op_addr = ~a;
      i_ccr = cbe_ccr_t'(4'(xorshift()));
      for (int n = 0; n < BRANCH_CYCLES && o_bus.rd !== 1'b1; n++) @(negedge i_ref_clk);
      check(o_bus, {1'b1, a});
      check({15'h0000, o_busy, o_done}, {15'h0000, 2'b10});
      @(negedge i_ref_clk);
      check(o_bus, {1'b1, a + 16'h0001});
      @(negedge i_ref_clk);
      check(o_bus, {1'b1, DUMMY_ADDR});
      i_start = 1'b0;
      @(negedge i_ref_clk);
      check({13'h0, o_done, o_busy, o_illegal, o_taken}, {13'h0, 2'b10, ill, tk});
      check({1'b0, o_pc}, {1'b0, pc_exp});
      check({13'h0, o_ccr}, {13'h0, f});
   endtask : run
   // Hang guard
   initial begin
      for (int n = 0; n < 50000; n++) @(posedge i_ref_clk);
      num_errors++;
      test_done();
   end
   // Main sequence
   initial begin
      logic [31:0] r;
      repeat (4) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      i_arst_n = 1'b1;
      repeat (3) @(negedge i_ref_clk);
      // Reset state: bus idle, counter at its reset value
      check(o_bus, 17'h00000);
      check({1'b0, o_pc}, {1'b0, PC_RESET});
      // Every branch opcode against every flag pattern, back to back
      for (int k = 0; k < 256; k++) begin
         r = xorshift();
         run(8'h20 + 8'(k[3:0]), r[7:0], r[31:16], cbe_ccr_t'(k[7:4]), r[8]);
      end
      // Offset extremes and address wrap
      run(OP_BRANCH_ALWAYS, 8'h80, 16'h0010, 4'h0, 1'b0);
      run(OP_BRANCH_ALWAYS, 8'h7f, 16'hfff0, 4'hf, 1'b1);
      run(OP_BRANCH_IF_MINUS, 8'hff, 16'h1234, 4'h8, 1'b0);
      run(OP_BRANCH_NEVER, 8'h80, 16'h4000, 4'hf, 1'b0);
      // Opcodes outside the family
      run(8'h1f, 8'h40, 16'h2000, 4'h0, 1'b0);
      run(8'h30, 8'h40, 16'h2000, 4'hf, 1'b0);
      test_done();
   end
endmodule : conditional_branch_evaluator_tb
`default_nettype wire
